// ---- include/inc_pkg.sv ----
// Shared constants for the inclinometer serial port, device end and host end
package inc_pkg;

	// Clock and frame timing
	localparam int CLK_PERIOD_PS = 10000;
	localparam int CS_TO_CLK_PS = 48800;
	localparam int SCLK_HALF_FAST_PS = 200000;
	localparam int SCLK_HALF_NORMAL_PS = 500000;
	localparam int FRAME_FAST_US = 40;
	localparam int FRAME_NORMAL_US = 100;
	localparam int CS_TO_CLK_CYC = (CS_TO_CLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCLK_HALF_FAST_CYC = (SCLK_HALF_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SCLK_HALF_NORMAL_CYC = (SCLK_HALF_NORMAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FRAME_FAST_CYC = (FRAME_FAST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FRAME_NORMAL_CYC = (FRAME_NORMAL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 14;

	// Frame layout
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_5 = 5'h10;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam int CMD_HI = 15;
	localparam int ADDR_HI = 13;
	localparam int ADDR_LO = 8;
	localparam int FRESH_BIT = 15;
	localparam int ALARM_BIT = 14;

	// Output data registers, byte addresses of the lower byte
	localparam logic [5:0] ADDR_SUPPLY = 6'h02;
	localparam logic [5:0] ADDR_AUX = 6'h08;
	localparam logic [5:0] ADDR_TEMP = 6'h0A;
	localparam logic [5:0] ADDR_INCL = 6'h0C;
	localparam logic [5:0] ADDR_INCL180 = 6'h0E;
	localparam int NREG = 5;
	localparam logic [2:0] IDX_SUPPLY = 3'h0;
	localparam logic [2:0] IDX_AUX = 3'h1;
	localparam logic [2:0] IDX_TEMP = 3'h2;
	localparam logic [2:0] IDX_INCL = 3'h3;
	localparam logic [2:0] IDX_INCL180 = 3'h4;
	localparam int VAL_W = 14;
	localparam int SHORT_W = 12;
	localparam logic [VAL_W-1:0] VAL_RESET = 14'h0000;
	localparam logic [15:0] WORD_UNMAPPED = 16'h0000;

	// States
	typedef enum logic [1:0] {DEV_IDLE = 2'b01, DEV_FRAME = 2'b10} inc_dev_e;
	typedef enum logic [4:0] {
		HST_IDLE = 5'b00001,
		HST_SETUP = 5'b00010,
		HST_LOW = 5'b00100,
		HST_HIGH = 5'b01000,
		HST_GAP = 5'b10000
	} inc_host_e;

endpackage : inc_pkg

// ---- include/inc_spi_if.sv ----
// Four-wire serial link plus reset pin between host and inclinometer
`timescale 1ns/1ns
interface inc_spi_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic rst_n;
	logic dout;
	logic dout_oe;
	logic miso;

	// Undriven data-out line is pulled high
	assign miso = dout_oe ? dout : 1'b1;

	modport dev (input sclk, input cs_n, input din, input rst_n, output dout, output dout_oe);
	modport host (output sclk, output cs_n, output din, output rst_n, input miso);
endinterface : inc_spi_if

// ---- design/inc_dev.sv ----
// Inclinometer serial slave port with its output data registers
// Function
// - Chip select high: output off, inputs ignored
// - Frame holds exactly sixteen clock cycles; longer ones act on their first sixteen bits
// - Full duplex sixteen bit shifting
// - Write: 1, 0, address, data byte
// - Write frame carries one byte only
// - Read: 00, address, eight ignored bits
// - Either byte address returns whole register
// - Read result leaves in next frame
// - Two byte addresses per register
// - Next read may ride on result frame
// - Data registers update at sample rate
// - Bit 15 fresh flag, cleared by read
// - Bit 14 flags active alarm
// - Values right aligned, 12 or 14 bits
// - Bits 13:12 of short values don't care
// - Half-circle angle 14-bit two's complement
// - Low reset pin restores initial state
// - MSB at select fall, rest after clock fall
// - Data in sampled on rising clock
// - Host spaces frames 40 or 100 us
`timescale 1ns/1ns
module inc_dev
	import inc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial link
	inc_spi_if.dev link,
	// Measurement feed
	input wire logic sample_strobe,
	input wire logic [SHORT_W-1:0] supply_value,
	input wire logic [SHORT_W-1:0] aux_value,
	input wire logic [SHORT_W-1:0] temp_value,
	input wire logic [VAL_W-1:0] full_circle_angle,
	input wire logic [VAL_W-1:0] signed_half_circle_angle,
	input wire logic alarm_active_flag,
	// Byte writes toward the control register set
	output logic wr_strobe,
	output logic [5:0] wr_addr,
	output logic [7:0] wr_data,
	// Status
	output logic [NREG-1:0] fresh_sample_flag
);

	typedef struct packed {
		inc_dev_e state;
		logic sclk_prev;
		logic [4:0] bit_cnt;
		logic [15:0] rx;
		logic [15:0] tx;
		logic dout;
		logic dout_oe;
		logic pend_valid;
		logic [5:0] pend_addr;
		logic sent_valid;
		logic [2:0] sent_idx;
		logic [NREG-1:0][VAL_W-1:0] val;
		logic [NREG-1:0] fresh;
		logic alarm;
		logic wr_stb;
		logic [5:0] wr_addr;
		logic [7:0] wr_data;
	} inc_dev_s;

	localparam inc_dev_s DEV_RESET = '{
		state: DEV_IDLE,
		sclk_prev: 1'b1,
		bit_cnt: 5'h00,
		rx: 16'h0000,
		tx: 16'h0000,
		dout: 1'b0,
		dout_oe: 1'b0,
		pend_valid: 1'b0,
		pend_addr: 6'h00,
		sent_valid: 1'b0,
		sent_idx: 3'h0,
		val: {NREG{VAL_RESET}},
		fresh: '0,
		alarm: 1'b0,
		wr_stb: 1'b0,
		wr_addr: 6'h00,
		wr_data: 8'h00
	};

	inc_dev_s q;
	inc_dev_s d;
	logic [2:0] sel_idx;
	logic sel_hit;
	logic sclk_rise;
	logic sclk_fall;
	logic [NREG-1:0] fresh_clr;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode: bit 0 picks a byte, ignored on read

	always_comb
	begin
		sel_hit = 1'b1;
		case (q.pend_addr[5:1])
			ADDR_SUPPLY[5:1]: sel_idx = IDX_SUPPLY;
			ADDR_AUX[5:1]: sel_idx = IDX_AUX;
			ADDR_TEMP[5:1]: sel_idx = IDX_TEMP;
			ADDR_INCL[5:1]: sel_idx = IDX_INCL;
			ADDR_INCL180[5:1]: sel_idx = IDX_INCL180;
			default:
			begin
				sel_idx = IDX_SUPPLY;
				sel_hit = 1'b0;
			end
		endcase
	end

	assign sclk_rise = link.sclk & ~q.sclk_prev;
	assign sclk_fall = ~link.sclk & q.sclk_prev;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		d = q;
		d.sclk_prev = link.sclk;
		d.wr_stb = 1'b0;
		fresh_clr = '0;

		// Registers keep loading whatever the host does
		if (sample_strobe)
		begin
			d.val[IDX_SUPPLY] = {2'b00, supply_value};
			d.val[IDX_AUX] = {2'b00, aux_value};
			d.val[IDX_TEMP] = {2'b00, temp_value};
			d.val[IDX_INCL] = full_circle_angle;
			d.val[IDX_INCL180] = signed_half_circle_angle;
			d.alarm = alarm_active_flag;
		end

		case (q.state)
			DEV_IDLE:
			begin
				d.dout_oe = 1'b0;
				d.bit_cnt = 5'h00;
				if (!link.cs_n)
				begin
					d.state = DEV_FRAME;
					d.dout_oe = 1'b1;
					// Result of last frame's read goes out now
					d.sent_valid = q.pend_valid & sel_hit;
					d.sent_idx = sel_idx;
					if (q.pend_valid && sel_hit)
					begin
						d.tx = {q.fresh[sel_idx], q.alarm, q.val[sel_idx]};
					end
					else
					begin
						d.tx = WORD_UNMAPPED;
					end
					d.pend_valid = 1'b0;
					d.dout = d.tx[FRESH_BIT];
				end
			end
			DEV_FRAME:
			begin
				if (link.cs_n)
				begin
					d.state = DEV_IDLE;
					d.dout_oe = 1'b0;
					// Short frames are discarded whole; long frames keep their first sixteen bits
					if (q.bit_cnt == FRAME_BITS_5)
					begin
						if (q.rx[CMD_HI -: 2] == CMD_WRITE)
						begin
							d.wr_stb = 1'b1;
							d.wr_addr = q.rx[ADDR_HI:ADDR_LO];
							d.wr_data = q.rx[7:0];
						end
						else if (q.rx[CMD_HI -: 2] == CMD_READ)
						begin
							d.pend_valid = 1'b1;
							d.pend_addr = q.rx[ADDR_HI:ADDR_LO];
						end
						if (q.sent_valid)
						begin
							fresh_clr[q.sent_idx] = 1'b1;
						end
					end
				end
				else
				begin
					if (sclk_rise && q.bit_cnt != FRAME_BITS_5)
					begin
						d.rx = {q.rx[14:0], link.din};
						d.bit_cnt = q.bit_cnt + 5'h01;
					end
					// First fall precedes any sample, so the MSB stays put
					if (sclk_fall && q.bit_cnt != 5'h00 && q.bit_cnt != FRAME_BITS_5)
					begin
						d.tx = {q.tx[14:0], 1'b0};
						d.dout = q.tx[14];
					end
				end
			end
			default:
			begin
				d.state = DEV_IDLE;
				d.dout_oe = 1'b0;
			end
		endcase

		// A load in the clearing cycle keeps the flag set
		d.fresh = (q.fresh & ~fresh_clr) | {NREG{sample_strobe}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; the pin reset acts like the system reset

	always_ff @(posedge clk)
	begin
		if (reset || !link.rst_n)
		begin
			q <= DEV_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	assign link.dout = q.dout;
	assign link.dout_oe = q.dout_oe;
	assign wr_strobe = q.wr_stb;
	assign wr_addr = q.wr_addr;
	assign wr_data = q.wr_data;
	assign fresh_sample_flag = q.fresh;

endmodule : inc_dev

// ---- design/inc_host.sv ----
// Host end: serial master that frames commands toward the inclinometer
`timescale 1ns/1ns
module inc_host
	import inc_pkg::*;
#(
	parameter int GAP_FAST_CYC = FRAME_FAST_CYC,
	parameter int GAP_NORMAL_CYC = FRAME_NORMAL_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial link
	inc_spi_if.host link,
	// Command port
	input wire logic start,
	input wire logic is_write,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic fast_mode,
	input wire logic dev_reset,
	output logic ready,
	output logic done,
	output logic [15:0] rdata
);

	typedef struct packed {
		inc_host_e state;
		logic [CNT_W-1:0] cnt;
		logic [4:0] bit_cnt;
		logic fast;
		logic sclk;
		logic cs_n;
		logic din;
		logic rst_n;
		logic [15:0] tx;
		logic [15:0] rx;
		logic ready;
		logic done;
		logic [15:0] rdata;
	} inc_host_s;

	localparam inc_host_s HOST_RESET = '{
		state: HST_IDLE,
		cnt: '0,
		bit_cnt: 5'h00,
		fast: 1'b0,
		sclk: 1'b1,
		cs_n: 1'b1,
		din: 1'b0,
		rst_n: 1'b0,
		tx: 16'h0000,
		rx: 16'h0000,
		ready: 1'b0,
		done: 1'b0,
		rdata: 16'h0000
	};

	localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(CS_TO_CLK_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_FAST_N = CNT_W'(SCLK_HALF_FAST_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_NORMAL_N = CNT_W'(SCLK_HALF_NORMAL_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_FAST_N = CNT_W'(GAP_FAST_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_NORMAL_N = CNT_W'(GAP_NORMAL_CYC - 1);

	inc_host_s q;
	inc_host_s d;
	logic [CNT_W-1:0] half_n;

	assign half_n = q.fast ? HALF_FAST_N : HALF_NORMAL_N;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		d.rst_n = ~dev_reset;
		if (q.cnt != '0)
		begin
			d.cnt = q.cnt - 1'b1;
		end
		case (q.state)
			HST_IDLE:
			begin
				d.ready = 1'b1;
				if (start)
				begin
					d.ready = 1'b0;
					d.fast = fast_mode;
					d.tx = is_write ? {CMD_WRITE, addr, wdata} : {CMD_READ, addr, 8'h00};
					d.cs_n = 1'b0;
					d.din = d.tx[15];
					d.bit_cnt = 5'h00;
					d.cnt = SETUP_N;
					d.state = HST_SETUP;
				end
			end
			HST_SETUP:
			begin
				if (q.cnt == '0)
				begin
					d.sclk = 1'b0;
					d.cnt = half_n;
					d.state = HST_LOW;
				end
			end
			HST_LOW:
			begin
				if (q.cnt == '0)
				begin
					d.sclk = 1'b1;
					d.rx = {q.rx[14:0], link.miso};
					d.bit_cnt = q.bit_cnt + 5'h01;
					d.cnt = half_n;
					d.state = HST_HIGH;
				end
			end
			HST_HIGH:
			begin
				if (q.cnt == '0)
				begin
					if (q.bit_cnt == FRAME_BITS_5)
					begin
						d.cs_n = 1'b1;
						d.rdata = q.rx;
						d.done = 1'b1;
						// Whole frame period counted from here, on the safe side
						d.cnt = q.fast ? GAP_FAST_N : GAP_NORMAL_N;
						d.state = HST_GAP;
					end
					else
					begin
						d.sclk = 1'b0;
						d.tx = {q.tx[14:0], 1'b0};
						d.din = q.tx[14];
						d.cnt = half_n;
						d.state = HST_LOW;
					end
				end
			end
			HST_GAP:
			begin
				if (q.cnt == '0)
				begin
					d.ready = 1'b1;
					d.state = HST_IDLE;
				end
			end
			default:
			begin
				d = HOST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			q <= HOST_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.din = q.din;
	assign link.rst_n = q.rst_n;
	assign ready = q.ready;
	assign done = q.done;
	assign rdata = q.rdata;

endmodule : inc_host

// ---- tb/inc_spi_properties.sv ----
// Link checker for the host and device ends of the serial port
`timescale 1ns/1ns
module inc_spi_properties
	import inc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic rst_n,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic miso
);
	logic sclk_q;
	logic [4:0] rise_q;
	logic cs_q;
	logic [CNT_W-1:0] period_q;
	// Shortest legal select period is the fast one
	localparam logic [CNT_W-1:0] PERIOD_MIN = CNT_W'(FRAME_FAST_CYC - 1);

	default clocking cb @(posedge clk); endclocking
	// Reset pin also clears the device, so both stop the checks
	default disable iff (reset || !rst_n);

	////////////////////////////////////////////////////////////////
	// Rising clock edges seen inside the current frame, saturating
	always_ff @(posedge clk)
	begin
		sclk_q <= sclk;
		if (reset || cs_n)
			rise_q <= 5'h00;
		else if (sclk && !sclk_q && rise_q != 5'h1F)
			rise_q <= rise_q + 5'h01;
	end

	// Cycles since the last select fall, saturating so the first frame passes
	always_ff @(posedge clk)
	begin
		cs_q <= cs_n;
		if (reset)
			period_q <= '1;
		else if (!cs_n && cs_q)
			period_q <= '0;
		else if (period_q != '1)
			period_q <= period_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////
	idle_tristate_a: assert property (cs_n && $past(cs_n) |-> !dout_oe) else $error("dout driven while idle");
	drive_cause_a: assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n)) else $error("dout driven early");
	drive_start_a: assert property ($fell(cs_n) |=> dout_oe) else $error("dout not driven");
	frame_count_a: assert property ($rose(cs_n) |-> rise_q == FRAME_BITS_5) else $error("frame not 16 clocks");
	clk_idle_a: assert property (cs_n && $past(cs_n) |-> sclk) else $error("clock low while idle");
	setup_wait_a: assert property ($fell(cs_n) |-> sclk [*4]) else $error("clock too soon");
	bit_hold_a: assert property (dout_oe && $past(dout_oe) && !$past(cs_n) && sclk && $past(sclk) |-> $stable(dout))
		else $error("dout moved while clock high");
	din_hold_a: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(din))
		else $error("din moved while clock high");
	frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("frames too close");
	frame_period_a: assert property ($fell(cs_n) |-> period_q >= PERIOD_MIN)
		else $error("select period too short");

	frame_end_c: cover property ($rose(cs_n));
	release_c: cover property ($fell(dout_oe) && miso);
	one_bit_c: cover property ($rose(sclk) && !cs_n && din);
endmodule : inc_spi_properties

// ---- tb/test_inclinometer_spi_register_port.sv ----
// Bench joining host end and device end across the serial link
`timescale 1ns/1ns
module test_inclinometer_spi_register_port
	import inc_pkg::*;
;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic is_write = 1'b0;
	logic fast_mode = 1'b1;
	logic dev_reset = 1'b0;
	logic sample_strobe = 1'b0;
	logic alarm = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00;
	logic [11:0] sup = 12'h000;
	logic [11:0] aux = 12'h123;
	logic [11:0] tmp = 12'h456;
	logic [13:0] full = 14'h2A5C;
	logic [13:0] half = 14'h3176;
	logic ready, done, wr_strobe;
	logic [15:0] rdata, r;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic [NREG-1:0] fresh;
	int fail_count = 0;
	int check_count = 0;
	int wr_cnt = 0;
	// Read address beside the word the following frame returns
	logic [21:0] rows [6] = '{{6'h02, 16'hCABC}, {6'h09, 16'hC123}, {6'h0A, 16'hC456},
		{6'h0D, 16'hEA5C}, {6'h0E, 16'hF176}, {6'h04, 16'h0000}};

	always #5 clk = ~clk;
	always @(posedge clk) if (wr_strobe === 1'b1) wr_cnt <= wr_cnt + 1;

	inc_spi_if link ();
	inc_dev inc_dev_i (.clk(clk), .reset(reset), .link(link), .sample_strobe(sample_strobe),
		.supply_value(sup), .aux_value(aux), .temp_value(tmp), .full_circle_angle(full),
		.signed_half_circle_angle(half), .alarm_active_flag(alarm), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .fresh_sample_flag(fresh));
	// Full frame spacing, so the period check covers the host too
	inc_host inc_host_i (.clk(clk), .reset(reset), .link(link),
		.start(start), .is_write(is_write), .addr(addr), .wdata(wdata), .fast_mode(fast_mode),
		.dev_reset(dev_reset), .ready(ready), .done(done), .rdata(rdata));
	inc_spi_properties inc_spi_properties_i (.clk(clk), .reset(reset), .sclk(link.sclk), .cs_n(link.cs_n),
		.din(link.din), .rst_n(link.rst_n), .dout(link.dout), .dout_oe(link.dout_oe), .miso(link.miso));

	////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task xfer(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [15:0] q);
		int n;
		for (n = 0; ready !== 1'b1; n++)
		begin
			if (n == 20000)
			begin
				fail_count++;
				conclude;
			end
			@(negedge clk);
		end
		start = 1'b1;
		is_write = w;
		addr = a;
		wdata = d;
		@(negedge clk);
		start = 1'b0;
		for (n = 0; done !== 1'b1; n++)
		begin
			if (n == 20000)
			begin
				fail_count++;
				conclude;
			end
			@(negedge clk);
		end
		q = rdata;
	endtask : xfer

	task load(input logic al, input logic [11:0] s);
		@(negedge clk);
		sup = s;
		alarm = al;
		sample_strobe = 1'b1;
		@(negedge clk);
		sample_strobe = 1'b0;
	endtask : load

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'(fresh), 16'h0000);
		chk(16'(link.dout_oe), 16'h0000);
		$display("reset test done");
		load(1'b1, 12'hABC);
		// Host sends a zero trailing byte on reads, so the all-ones data argument goes unused
		xfer(1'b0, rows[0][21:16], 8'hFF, r);
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b0, rows[(i + 1) % 6][21:16], 8'h00, r);
			chk(r, rows[i][15:0]);
		end
		chk(16'(fresh), 16'h0000);
		$display("read table test done");
		fast_mode = 1'b0;
		xfer(1'b0, 6'h03, 8'h00, r);
		chk(r, 16'h4ABC);
		fast_mode = 1'b1;
		xfer(1'b1, 6'h36, 8'h5A, r);
		chk(r, 16'h4ABC);
		// Write strobe lands one edge after select rises
		repeat (3) @(negedge clk);
		chk({2'b00, wr_addr, wr_data}, 16'h365A);
		chk(16'(wr_cnt), 16'h0001);
		$display("write test done");
		load(1'b1, 12'h777);
		dev_reset = 1'b1;
		repeat (4) @(negedge clk);
		dev_reset = 1'b0;
		repeat (2) @(negedge clk);
		chk(16'(fresh), 16'h0000);
		$display("reset pin test done");
		load(1'b0, 12'h5A5);
		xfer(1'b0, 6'h02, 8'h00, r);
		xfer(1'b0, 6'h0C, 8'h00, r);
		chk(r, 16'h85A5);
		$display("reload test done");
		conclude;
	end
endmodule : test_inclinometer_spi_register_port
